// ---- rtl/iocfg_clkout.sv ----
// host clock output generator
`timescale 1ns/100ps
`include "iocfg_params.svh"
module iocfg_clkout (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic xtal_running,
  input wire logic ref_level,
  input wire logic lf_level,
  input iocfg_pkg::iocfg_clk_sel_t clk_sel,
  input wire logic slow_suppress,
  output logic clk_out
);
  import iocfg_pkg::*;

  logic ref_d_reg;
  logic [`IOCFG_DIV_W-1:0] div_reg;
  logic clk_next;
  wire ref_rise = ref_level & ~ref_d_reg;

  // crystal reference is twice 13.56 MHz, so each counter bit halves it again
  always_comb begin
    clk_next = 1'b0;
    case (clk_sel)
      IOCFG_CLK_3M39: clk_next = xtal_running ? div_reg[`IOCFG_DIV_3M39] : lf_level;
      IOCFG_CLK_6M78: clk_next = xtal_running ? div_reg[`IOCFG_DIV_6M78] : lf_level;
      IOCFG_CLK_13M56: clk_next = xtal_running ? div_reg[`IOCFG_DIV_13M56] : lf_level;
      IOCFG_CLK_OFF: clk_next = 1'b0;
      default: clk_next = 1'b0;
    endcase
    if (!xtal_running && slow_suppress) begin
      clk_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_d_reg <= 1'b0;
      div_reg <= '0;
      clk_out <= 1'b0;
    end else if (ce) begin
      ref_d_reg <= ref_level;
      if (ref_rise) begin
        div_reg <= div_reg + 1'b1;
      end
      clk_out <= clk_next;
    end
  end

  AST_HCLK_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && clk_sel == IOCFG_CLK_OFF) |=> !clk_out)
    else $error("host clock not low while disabled");
  AST_SLOW_CLK: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !xtal_running && clk_sel != IOCFG_CLK_OFF) |=>
      (clk_out == ($past(lf_level) && !$past(slow_suppress))))
    else $error("slow clock output wrong");
  AST_FREQ_6M78: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && xtal_running && clk_sel == IOCFG_CLK_6M78 && ref_rise) ##1
      (ce && xtal_running && clk_sel == IOCFG_CLK_6M78) |=>
      (clk_out == $past(div_reg[`IOCFG_DIV_6M78])))
    else $error("6.78 MHz tap not on output");
endmodule

// ---- rtl/iocfg_params.svh ----
// constants for the io configuration register bank
// How it works
// - io setup one bit 7 clear drives both antenna outputs; set uses one driver
// - in one-ended drive bit 6 picks output/input pair a (0) or b (1)
// - with crystal running, clock select 00/01/10 gives 3.39/6.78/13.56 MHz
// - clock select 11 disables the host clock output and holds it low
// - bit 0 clear, crystal stopped, output enabled: slow clock on host clock output
// - tuning converters run only when tuning enable and oscillator enable are set
// - operation control bit 7 turns on oscillator and regulator, ready mode
// - io setup two bit 4: miso pull-down while selected and miso not driven
// - io setup two bit 3: miso pull-down while deselected
// - both miso pull-downs act only when the host interface is in spi mode
// - bit 1 picks modulation regulator reference: driver supply 0, rf supply 1
`ifndef IOCFG_PARAMS_SVH
`define IOCFG_PARAMS_SVH

// -----------------------------------------------------------------------------
// register indices, byte address is four times the index
// -----------------------------------------------------------------------------
`define IOCFG_IDX_SETUP_ONE 8'h00
`define IOCFG_IDX_SETUP_TWO 8'h01
`define IOCFG_IDX_OP_CTRL 8'h02
`define IOCFG_IDX_STATUS 8'h10
`define IOCFG_RESET_BYTE 8'h00
`define IOCFG_ONE_WR_MASK 8'hF7

// -----------------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------------
`define IOCFG_B_SINGLE 7
`define IOCFG_B_ALT_PAIR 6
`define IOCFG_B_I2C_HOLD_HI 5
`define IOCFG_B_I2C_HOLD_LO 4
`define IOCFG_B_CLK_SEL_HI 2
`define IOCFG_B_CLK_SEL_LO 1
`define IOCFG_B_SLOW_SUPP 0
`define IOCFG_B_SUP3V 7
`define IOCFG_B_DREG_OFF 6
`define IOCFG_B_AAT_EN 5
`define IOCFG_B_PD_SEL 4
`define IOCFG_B_PD_DESEL 3
`define IOCFG_B_DRV_BOOST 2
`define IOCFG_B_REF_RF 1
`define IOCFG_B_ACT_SINK 0
`define IOCFG_B_OSC_EN 7
`define IOCFG_ST_XTAL 0
`define IOCFG_ST_SPI 1
`define IOCFG_ST_SEL_N 2
`define IOCFG_ST_HCLK 3
`define IOCFG_ST_EN_SEEN 4

// -----------------------------------------------------------------------------
// host clock divider taps on the crystal reference edge counter
// -----------------------------------------------------------------------------
`define IOCFG_DIV_13M56 0
`define IOCFG_DIV_6M78 1
`define IOCFG_DIV_3M39 2
`define IOCFG_DIV_W 3

// -----------------------------------------------------------------------------
// bus answers
// -----------------------------------------------------------------------------
`define IOCFG_RESP_OKAY 2'h0
`define IOCFG_RESP_SLVERR 2'h2

`endif

// ---- rtl/iocfg_pkg.sv ----
// types shared by the io configuration register bank
package iocfg_pkg;
  typedef enum logic [1:0] {IOCFG_CLK_3M39, IOCFG_CLK_6M78, IOCFG_CLK_13M56, IOCFG_CLK_OFF}
    iocfg_clk_sel_t;
  typedef enum logic {IOCFG_WR_COLLECT, IOCFG_WR_RESP} iocfg_wr_state_t;
  typedef enum logic {IOCFG_RD_IDLE, IOCFG_RD_RESP} iocfg_rd_state_t;
endpackage

// ---- rtl/iocfg_sync.sv ----
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module iocfg_sync #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_reg[i] <= 1'b0;
          q[i] <= 1'b0;
        end else if (ce) begin
          meta_reg[i] <= d[i];
          q[i] <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule

// ---- rtl/iocfg_top.sv ----
// io configuration register bank with its axi4-lite slave
`timescale 1ns/100ps
`include "iocfg_params.svh"
module iocfg_top #(
  parameter int ADDR_W = 10
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic XTAL_RUNNING,
  input wire logic XTAL_REF_CLK,
  input wire logic SLOW_CLK_IN,
  input wire logic SPI_SELECT_N,
  input wire logic SPI_MODE,
  input wire logic MISO_DRIVEN,
  output logic HOST_CLK_OUT,
  output logic DIFF_DRIVE,
  output logic ANTENNA_OUT_A_EN,
  output logic ANTENNA_OUT_B_EN,
  output logic ANTENNA_IN_B_SEL,
  output logic AAT_DAC_EN,
  output logic AAT_HOLD_FIXED,
  output logic OSC_REG_EN,
  output logic MISO_PULLDOWN_EN,
  output logic IO_DRIVE_BOOST,
  output logic MOD_REG_REF_RF,
  output logic [1:0] I2C_HOLD_SEL,
  output logic SUPPLY_3V3,
  output logic DIG_REG_OFF,
  output logic AM_ACTIVE_SINK
);
  import iocfg_pkg::*;

  // ---------------------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_ONE = ADDR_W'({`IOCFG_IDX_SETUP_ONE, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_TWO = ADDR_W'({`IOCFG_IDX_SETUP_TWO, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_OP = ADDR_W'({`IOCFG_IDX_OP_CTRL, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_ST = ADDR_W'({`IOCFG_IDX_STATUS, 2'b00});

  logic [7:0] io1_reg;
  logic [7:0] io2_reg;
  logic [7:0] op_reg;
  logic en_seen_reg;

  iocfg_wr_state_t wr_state_reg;
  iocfg_wr_state_t wr_state_next;
  iocfg_rd_state_t rd_state_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic aw_have_next;
  logic w_have_next;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [31:0] wr_data_reg;
  logic [3:0] wr_strb_reg;

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  logic [3:0] pin_sync;

  iocfg_sync #(
    .W(4)
  ) u_sync (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .ce(CE),
    .d({SPI_SELECT_N, SLOW_CLK_IN, XTAL_REF_CLK, XTAL_RUNNING}),
    .q(pin_sync)
  );

  wire xtal_s = pin_sync[0];
  wire ref_s = pin_sync[1];
  wire slow_s = pin_sync[2];
  wire select_n_s = pin_sync[3];

  // ---------------------------------------------------------------------------
  // write channel
  // ---------------------------------------------------------------------------
  wire aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
  wire w_take = S_AXI_WVALID & S_AXI_WREADY;
  wire wr_fire = (wr_state_reg == IOCFG_WR_COLLECT) & aw_have_reg & w_have_reg;
  wire b_done = S_AXI_BVALID & S_AXI_BREADY;
  wire wr_lane0 = wr_strb_reg[0];
  wire wr_hit_one = wr_addr_reg == ADDR_ONE;
  wire wr_hit_two = wr_addr_reg == ADDR_TWO;
  wire wr_hit_op = wr_addr_reg == ADDR_OP;
  wire wr_ok = wr_hit_one | wr_hit_two | wr_hit_op;
  wire wr_one = wr_fire & wr_hit_one & wr_lane0;
  wire wr_two = wr_fire & wr_hit_two & wr_lane0;
  wire wr_op = wr_fire & wr_hit_op & wr_lane0;
  wire [7:0] wr_byte = wr_data_reg[7:0];

  always_comb begin
    wr_state_next = wr_state_reg;
    aw_have_next = aw_have_reg | aw_take;
    w_have_next = w_have_reg | w_take;
    case (wr_state_reg)
      IOCFG_WR_COLLECT: begin
        if (wr_fire) begin
          wr_state_next = IOCFG_WR_RESP;
        end
      end
      IOCFG_WR_RESP: begin
        if (b_done) begin
          wr_state_next = IOCFG_WR_COLLECT;
          aw_have_next = 1'b0;
          w_have_next = 1'b0;
        end
      end
      default: wr_state_next = IOCFG_WR_COLLECT;
    endcase
  end

  // address and data may arrive in either order; each is held until both are in
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_state_reg <= IOCFG_WR_COLLECT;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
    end else if (CE) begin
      wr_state_reg <= wr_state_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      S_AXI_AWREADY <= (wr_state_next == IOCFG_WR_COLLECT) & ~aw_have_next;
      S_AXI_WREADY <= (wr_state_next == IOCFG_WR_COLLECT) & ~w_have_next;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
      wr_strb_reg <= '0;
    end else if (CE) begin
      if (aw_take) begin
        wr_addr_reg <= S_AXI_AWADDR;
      end
      if (w_take) begin
        wr_data_reg <= S_AXI_WDATA;
        wr_strb_reg <= S_AXI_WSTRB;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `IOCFG_RESP_OKAY;
    end else if (CE) begin
      if (wr_fire) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_ok ? `IOCFG_RESP_OKAY : `IOCFG_RESP_SLVERR;
      end else if (b_done) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      io1_reg <= `IOCFG_RESET_BYTE;
      io2_reg <= `IOCFG_RESET_BYTE;
      op_reg <= `IOCFG_RESET_BYTE;
    end else if (CE) begin
      if (wr_one) begin
        io1_reg <= wr_byte & `IOCFG_ONE_WR_MASK;
      end
      if (wr_two) begin
        io2_reg <= wr_byte;
      end
      if (wr_op) begin
        op_reg <= wr_byte;
      end
    end
  end

  // remembers that the oscillator was ever enabled; only reset forgets it
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      en_seen_reg <= 1'b0;
    end else if (CE && op_reg[`IOCFG_B_OSC_EN]) begin
      en_seen_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------------------
  wire ar_take = S_AXI_ARVALID & S_AXI_ARREADY;
  wire r_done = S_AXI_RVALID & S_AXI_RREADY;
  wire rd_hit_one = S_AXI_ARADDR == ADDR_ONE;
  wire rd_hit_two = S_AXI_ARADDR == ADDR_TWO;
  wire rd_hit_op = S_AXI_ARADDR == ADDR_OP;
  wire rd_hit_st = S_AXI_ARADDR == ADDR_ST;
  wire rd_ok = rd_hit_one | rd_hit_two | rd_hit_op | rd_hit_st;
  wire [7:0] status_byte = {3'h0, en_seen_reg, HOST_CLK_OUT, select_n_s, SPI_MODE, xtal_s};
  wire [7:0] rd_byte = rd_hit_one ? io1_reg :
                       rd_hit_two ? io2_reg :
                       rd_hit_op ? op_reg :
                       rd_hit_st ? status_byte : 8'h00;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rd_state_reg <= IOCFG_RD_IDLE;
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `IOCFG_RESP_OKAY;
    end else if (CE) begin
      case (rd_state_reg)
        IOCFG_RD_IDLE: begin
          if (ar_take) begin
            rd_state_reg <= IOCFG_RD_RESP;
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= {24'h00_0000, rd_byte};
            S_AXI_RRESP <= rd_ok ? `IOCFG_RESP_OKAY : `IOCFG_RESP_SLVERR;
          end
        end
        IOCFG_RD_RESP: begin
          if (r_done) begin
            rd_state_reg <= IOCFG_RD_IDLE;
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID <= 1'b0;
          end
        end
        default: rd_state_reg <= IOCFG_RD_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // device controls
  // ---------------------------------------------------------------------------
  wire single_w = io1_reg[`IOCFG_B_SINGLE];
  wire alt_driver_pair_sel = io1_reg[`IOCFG_B_ALT_PAIR];
  wire osc_en_w = op_reg[`IOCFG_B_OSC_EN];
  wire aat_en_w = io2_reg[`IOCFG_B_AAT_EN];
  wire spi_out_pulldown_selected = io2_reg[`IOCFG_B_PD_SEL];
  wire spi_out_pulldown_deselected = io2_reg[`IOCFG_B_PD_DESEL];
  wire mod_regulator_ref_sel = io2_reg[`IOCFG_B_REF_RF];
  wire slow_clock_suppress = io1_reg[`IOCFG_B_SLOW_SUPP];
  wire host_clk_freq_sel_hi = io1_reg[`IOCFG_B_CLK_SEL_HI];
  wire host_clk_freq_sel_lo = io1_reg[`IOCFG_B_CLK_SEL_LO];
  wire [1:0] clk_sel_bits = {host_clk_freq_sel_hi, host_clk_freq_sel_lo};
  wire iocfg_clk_sel_t clk_sel_w = iocfg_clk_sel_t'(clk_sel_bits);

  wire out_a_next = ~single_w | ~alt_driver_pair_sel;
  wire out_b_next = ~single_w | alt_driver_pair_sel;
  wire in_b_next = single_w & alt_driver_pair_sel;
  wire aat_run_next = aat_en_w & osc_en_w;
  // the fixed value only holds once the oscillator has run at least once
  wire aat_hold_next = aat_en_w & ~osc_en_w & en_seen_reg;
  wire pd_sel_term = spi_out_pulldown_selected & ~select_n_s & ~MISO_DRIVEN;
  wire pd_desel_term = spi_out_pulldown_deselected & select_n_s;
  wire pd_next = SPI_MODE & (pd_sel_term | pd_desel_term);

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DIFF_DRIVE <= 1'b1;
      ANTENNA_OUT_A_EN <= 1'b1;
      ANTENNA_OUT_B_EN <= 1'b1;
      ANTENNA_IN_B_SEL <= 1'b0;
      AAT_DAC_EN <= 1'b0;
      AAT_HOLD_FIXED <= 1'b0;
      OSC_REG_EN <= 1'b0;
      MISO_PULLDOWN_EN <= 1'b0;
    end else if (CE) begin
      DIFF_DRIVE <= ~single_w;
      ANTENNA_OUT_A_EN <= out_a_next;
      ANTENNA_OUT_B_EN <= out_b_next;
      ANTENNA_IN_B_SEL <= in_b_next;
      AAT_DAC_EN <= aat_run_next;
      AAT_HOLD_FIXED <= aat_hold_next;
      OSC_REG_EN <= osc_en_w;
      MISO_PULLDOWN_EN <= pd_next;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      IO_DRIVE_BOOST <= 1'b0;
      MOD_REG_REF_RF <= 1'b0;
      I2C_HOLD_SEL <= 2'h0;
      SUPPLY_3V3 <= 1'b0;
      DIG_REG_OFF <= 1'b0;
      AM_ACTIVE_SINK <= 1'b0;
    end else if (CE) begin
      IO_DRIVE_BOOST <= io2_reg[`IOCFG_B_DRV_BOOST];
      MOD_REG_REF_RF <= mod_regulator_ref_sel;
      I2C_HOLD_SEL <= {io1_reg[`IOCFG_B_I2C_HOLD_HI], io1_reg[`IOCFG_B_I2C_HOLD_LO]};
      SUPPLY_3V3 <= io2_reg[`IOCFG_B_SUP3V];
      DIG_REG_OFF <= io2_reg[`IOCFG_B_DREG_OFF];
      AM_ACTIVE_SINK <= io2_reg[`IOCFG_B_ACT_SINK];
    end
  end

  // ---------------------------------------------------------------------------
  // host clock output
  // ---------------------------------------------------------------------------
  iocfg_clkout u_clkout (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .ce(CE),
    .xtal_running(xtal_s),
    .ref_level(ref_s),
    .lf_level(slow_s),
    .clk_sel(clk_sel_w),
    .slow_suppress(slow_clock_suppress),
    .clk_out(HOST_CLK_OUT)
  );

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  AST_DIFF_DRIVE: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (CE && !single_w) |=> (DIFF_DRIVE && ANTENNA_OUT_A_EN && ANTENNA_OUT_B_EN))
    else $error("differential drive not on both outputs");
  AST_PAIR_SEL: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (CE && single_w) |=> (ANTENNA_OUT_B_EN == $past(alt_driver_pair_sel)) &&
      (ANTENNA_OUT_A_EN != ANTENNA_OUT_B_EN) && (ANTENNA_IN_B_SEL == ANTENNA_OUT_B_EN))
    else $error("one-ended pair selection wrong");
  AST_AAT_RUN: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    CE |=> (AAT_DAC_EN == ($past(aat_en_w) && $past(osc_en_w))))
    else $error("tuning converters enabled wrongly");
  AST_AAT_HOLD: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (CE && aat_en_w && !osc_en_w && !en_seen_reg) |=> !AAT_HOLD_FIXED)
    else $error("fixed tuning value before oscillator ever ran");
  AST_READY: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (CE && wr_op && wr_byte[`IOCFG_B_OSC_EN]) ##1 CE |=> OSC_REG_EN)
    else $error("oscillator enable write not seen on output");
  AST_PD_SELECTED: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (CE && SPI_MODE && spi_out_pulldown_selected && !select_n_s && !MISO_DRIVEN)
      |=> MISO_PULLDOWN_EN)
    else $error("selected pull-down missing");
  AST_PD_DESELECTED: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (CE && SPI_MODE && spi_out_pulldown_deselected && select_n_s) |=> MISO_PULLDOWN_EN)
    else $error("deselected pull-down missing");
  AST_PD_SPI_ONLY: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (CE && !SPI_MODE) |=> !MISO_PULLDOWN_EN)
    else $error("pull-down active outside spi mode");
  AST_AM_REF: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    CE |=> (MOD_REG_REF_RF == $past(mod_regulator_ref_sel)))
    else $error("regulator reference select wrong");
  AST_WRITE_ONE: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (CE && wr_one) |=> (io1_reg == ($past(wr_byte) & `IOCFG_ONE_WR_MASK)))
    else $error("setup one did not take the written value");
  AST_BVALID_HOLD: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (S_AXI_BVALID && !S_AXI_BREADY) |=> S_AXI_BVALID)
    else $error("write response dropped before taken");
endmodule

// ---- verification/io_configuration_registers_tb_top.sv ----
// self-checking bench for the io configuration register bank
`timescale 1ns/100ps
`include "iocfg_params.svh"
module io_configuration_registers_tb_top;
  logic clk = 0, rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic xrun = 0, seln = 1, spim = 0, mdrv = 0;
  logic [9:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat, d;
  logic [1:0] brsp, rrsp, r, ihs;
  logic awr, wrdy, bv, arr, rv, xref, slow, hclk, diff, aen, ben, bsel, dac, hold, osc;
  logic pd, boost, refrf, s3, dro, sink;
  int num_errors = 0, checks_done = 0, i, n;

  always #4 clk = ~clk;

  iocfg_top dut_u (.CORE_CLK(clk), .RESET_N(rst_n), .CE(1'b1),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(brsp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rrsp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rry), .XTAL_RUNNING(xrun), .XTAL_REF_CLK(xref), .SLOW_CLK_IN(slow),
    .SPI_SELECT_N(seln), .SPI_MODE(spim), .MISO_DRIVEN(mdrv), .HOST_CLK_OUT(hclk),
    .DIFF_DRIVE(diff), .ANTENNA_OUT_A_EN(aen), .ANTENNA_OUT_B_EN(ben),
    .ANTENNA_IN_B_SEL(bsel), .AAT_DAC_EN(dac), .AAT_HOLD_FIXED(hold), .OSC_REG_EN(osc),
    .MISO_PULLDOWN_EN(pd), .IO_DRIVE_BOOST(boost), .MOD_REG_REF_RF(refrf),
    .I2C_HOLD_SEL(ihs), .SUPPLY_3V3(s3), .DIG_REG_OFF(dro), .AM_ACTIVE_SINK(sink));

  iocfg_pin_model env_u (.clk(clk), .rst_n(rst_n), .xtal_ref(xref), .slow_clk(slow));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ready and response are sampled one step after an edge, then acted on at the next edge that takes them
  task wset(input logic [7:0] idx, input logic [7:0] v);
    logic a, w, b;
    awa <= {idx, 2'b00};
    wd <= {24'h0, v};
    awv <= 1;
    wv <= 1;
    bry <= 1;
    forever begin
      #1;
      a = awr;
      w = wrdy;
      b = bv;
      r = brsp;
      @(posedge clk);
      if (a) awv <= 0;
      if (w) wv <= 0;
      if (b) break;
    end
    // ready lines stay high between calls so no signal is driven twice in one step
    chk(r, `IOCFG_RESP_OKAY);
  endtask

  task rd(input logic [7:0] idx);
    logic a, v;
    ara <= {idx, 2'b00};
    arv <= 1;
    rry <= 1;
    forever begin
      #1;
      a = arr;
      v = rv;
      d = rdat;
      r = rrsp;
      @(posedge clk);
      if (a) arv <= 0;
      if (v) break;
    end
  endtask

  task cnt_tog;
    logic p;
    n = 0;
    #1;
    p = hclk;
    repeat (64) begin
      @(posedge clk);
      #1;
      if (hclk !== p) n++;
      p = hclk;
    end
    @(posedge clk);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    rd(`IOCFG_IDX_SETUP_ONE);
    chk(d, 0);
    rd(`IOCFG_IDX_SETUP_TWO);
    chk(d, 0);
    wset(`IOCFG_IDX_SETUP_ONE, 8'hFF);
    rd(`IOCFG_IDX_SETUP_ONE);
    chk(d, 32'hF7);
    chk(ihs, 2'b11);
    wset(`IOCFG_IDX_SETUP_TWO, 8'hFF);
    rd(`IOCFG_IDX_SETUP_TWO);
    chk(d, 32'hFF);
    chk({s3, dro, sink}, 3'b111);
    rd(8'h05);
    chk(d, 32'h0);
    chk(r, `IOCFG_RESP_SLVERR);
    for (i = 0; i < 4; i++) begin
      wset(`IOCFG_IDX_SETUP_ONE, {i[1:0], 6'h0});
      repeat (3) @(posedge clk);
      chk({diff, aen, ben, bsel}, {!i[1], !i[1] | !i[0], !i[1] | i[0], i[1] & i[0]});
    end
    xrun <= 1;
    for (i = 0; i < 4; i++) begin
      wset(`IOCFG_IDX_SETUP_ONE, {5'h0, i[1:0], 1'b0});
      repeat (8) @(posedge clk);
      cnt_tog;
      // taps: 3.39 MHz toggles 8 times in 64 cycles, each faster step doubles
      if (i < 3) chk(n >= (8 << i) - 1 && n <= (8 << i) + 1, 1);
      else chk({n[7:0], hclk}, 9'h0);
    end
    xrun <= 0;
    wset(`IOCFG_IDX_SETUP_ONE, 8'h00);
    repeat (8) @(posedge clk);
    cnt_tog;
    chk(n >= 3 && n <= 5, 1);
    wset(`IOCFG_IDX_SETUP_ONE, 8'h01);
    repeat (8) @(posedge clk);
    cnt_tog;
    chk({n[7:0], hclk}, 9'h0);
    wset(`IOCFG_IDX_SETUP_TWO, 8'h20);
    repeat (3) @(posedge clk);
    chk({dac, hold, osc}, 3'b000);
    wset(`IOCFG_IDX_OP_CTRL, 8'h80);
    repeat (3) @(posedge clk);
    chk({dac, hold, osc}, 3'b101);
    rd(`IOCFG_IDX_OP_CTRL);
    chk(d, 32'h80);
    wset(`IOCFG_IDX_OP_CTRL, 8'h00);
    repeat (3) @(posedge clk);
    chk({dac, hold, osc}, 3'b010);
    rd(`IOCFG_IDX_STATUS);
    chk(d, 32'h14);
    for (i = 0; i < 4; i++) begin
      wset(`IOCFG_IDX_SETUP_TWO, {5'h0, i[1:0], 1'b0});
      repeat (3) @(posedge clk);
      chk({boost, refrf}, i[1:0]);
    end
    for (i = 0; i < 32; i++) begin
      wset(`IOCFG_IDX_SETUP_TWO, {3'h0, i[0], i[1], 3'h0});
      spim <= i[2];
      seln <= i[3];
      mdrv <= i[4];
      repeat (6) @(posedge clk);
      chk(pd, i[2] & ((i[0] & !i[3] & !i[4]) | (i[1] & i[3])));
    end
    give_verdict;
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict;
  end
endmodule

// ---- verification/iocfg_pin_model.sv ----
// pin-side model: crystal reference and slow clock
`timescale 1ns/100ps
module iocfg_pin_model #(
  parameter int SLOW_HALF = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic xtal_ref,
  output logic slow_clk
);
  int cnt;
  // ref toggles on every rising clock edge so the divider taps give exact counts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xtal_ref <= 1'b0;
      slow_clk <= 1'b0;
      cnt <= 0;
    end else begin
      xtal_ref <= ~xtal_ref;
      cnt <= (cnt == SLOW_HALF - 1) ? 0 : cnt + 1;
      if (cnt == SLOW_HALF - 1) begin
        slow_clk <= ~slow_clk;
      end
    end
  end
endmodule
